/* verilog/gpblk_port.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - up to fifty pins, shared pins allowed
// RULE2 - eight drive modes per pin
// RULE3 - per pin CMOS or LVTTL threshold
// RULE4 - input and output disabled independently
// RULE5 - hold latches pin state for sleep
// RULE6 - per pin slew rate select
// RULE7 - ports of eight pins, own config
// RULE8 - reset forces all drivers disabled
// RULE9 - per pin mux: register or peripheral
// RULE10 - output register and sensed state register
// RULE11 - edge interrupt only when enabled
// RULE12 - port events merge into one request
// RULE13 - reset wake leaves pins high impedance
// RULE14 - interrupt wake keeps held drivers
// RULE15 - edge select, pending cleared writing one
// RULE16 - inputs synchronised two stages first
module gpblk_port
  import gpblk_pkg::*;
#(
  // RULE1 ports tile up to fifty pins
  parameter int W = GPBLK_PORT_W
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire gpblk_cfg_t           cfg_i,
  input  wire logic                 cfg_wr_i,
  input  wire logic                 hold_i,
  input  wire logic                 sleep_i,
  input  wire logic [GPBLK_PORT_W-1:0] periph_out_i,
  input  wire logic [GPBLK_PORT_W-1:0] periph_oe_i,
  input  wire logic [GPBLK_PORT_W-1:0] int_clr_i,
  input  wire logic [GPBLK_PORT_W-1:0] pin_in_i,
  output gpblk_pad_t                pad_o,
  output logic [GPBLK_PORT_W-1:0]   pin_state_o,
  output logic [GPBLK_PORT_W-1:0]   periph_in_o,
  output logic [GPBLK_PORT_W-1:0]   int_pend_o,
  output logic                      irq_o
);

  ////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [GPBLK_PORT_W-1:0] sync1;
    logic [GPBLK_PORT_W-1:0] sync2;
    logic [GPBLK_PORT_W-1:0] state;
    logic [GPBLK_PORT_W-1:0] pend;
    logic                    irq;
    logic                    frozen;
    // set one, two and three edges after reset: sync chain filled
    logic                    fill1;
    logic                    fill2;
    logic                    fill3;
    gpblk_pad_t              pad;
  } gpblk_st_t;

  gpblk_st_t st_reg;
  gpblk_st_t st_next;

  // edge match for one pin under its edge selection
  function automatic logic gpblk_edge_hit(input logic [1:0] sel, input logic prev,
                                          input logic cur);
    gpblk_edge_hit = ((sel == GPBLK_EDGE_RISE || sel == GPBLK_EDGE_BOTH) && !prev && cur) ||
                     ((sel == GPBLK_EDGE_FALL || sel == GPBLK_EDGE_BOTH) && prev && !cur);
  endfunction : gpblk_edge_hit

  // drive modes that actively source or sink the pin
  function automatic logic gpblk_drives(input logic [2:0] dm);
    gpblk_drives = (dm != GPBLK_DM_OFF) && (dm != GPBLK_DM_INONLY);
  endfunction : gpblk_drives

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic hit;
    hit = 1'b0;
    st_next = st_reg;
    // RULE16 two stage sync
    st_next.sync1 = pin_in_i;
    st_next.sync2 = st_reg.sync1;
    // fill flags ride with the sync chain; edges wait until the state
    // register holds a real pin level, else a pin idling high would
    // look like a rising edge right after reset
    st_next.fill1 = 1'b1;
    st_next.fill2 = st_reg.fill1;
    st_next.fill3 = st_reg.fill2;
    // RULE10 sensed level register, gated by input disable
    // RULE4 input disable
    st_next.state = st_reg.sync2 & ~cfg_i.in_dis;
    for (int i = 0; i < W; i++) begin
      // RULE11 edge event when enabled
      // RULE15 set beats clear
      hit = gpblk_edge_hit(cfg_i.edge_sel[i], st_reg.state[i], st_reg.sync2[i]);
      hit = hit && st_reg.fill3 && !cfg_i.in_dis[i];
      st_next.pend[i] = hit | (st_reg.pend[i] & ~int_clr_i[i]);
    end
    // RULE12 one request per port
    st_next.irq = |st_next.pend;
    // RULE5 hold freezes pads; RULE14 released only by new config or reset
    if (hold_i && sleep_i) begin
      st_next.frozen = 1'b1;
    end else if (cfg_wr_i) begin
      st_next.frozen = 1'b0;
    end
    if (!st_next.frozen) begin
      for (int i = 0; i < W; i++) begin
        // RULE9 register or peripheral source
        st_next.pad.out_val[i] = cfg_i.periph_sel[i] ? periph_out_i[i] : cfg_i.data_out[i];
        // RULE2 drive mode; RULE4 output disable
        st_next.pad.out_en[i] = gpblk_drives(cfg_i.drive_mode[i]) && !cfg_i.out_dis[i] &&
                                (!cfg_i.periph_sel[i] || periph_oe_i[i]);
      end
      st_next.pad.drive_mode = cfg_i.drive_mode;
      // RULE3 threshold select
      st_next.pad.lvttl_sel  = cfg_i.lvttl_sel;
      st_next.pad.in_en      = ~cfg_i.in_dis;
      // RULE6 slew select
      st_next.pad.slew_slow  = cfg_i.slew_slow;
    end
  end

  // RULE8 reset disables drivers; RULE13 reset wake is high impedance
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // RULE7 eight pin port outputs, all from flops
  assign pad_o       = st_reg.pad;
  assign pin_state_o = st_reg.state;
  assign periph_in_o = st_reg.state;
  assign int_pend_o  = st_reg.pend;
  assign irq_o       = st_reg.irq;

  ////////////////////////////////////////////////////////////////
  // per-pin checks watch pins 0 and 1 only; the loop makes every pin alike
  // a live rising or falling edge on pin 0 that its edge selection accepts
  sequence s_rise0;
    st_reg.fill3 && !cfg_i.in_dis[0] && !st_reg.state[0] && st_reg.sync2[0] &&
    (cfg_i.edge_sel[0] == GPBLK_EDGE_RISE || cfg_i.edge_sel[0] == GPBLK_EDGE_BOTH);
  endsequence

  sequence s_fall0;
    st_reg.fill3 && !cfg_i.in_dis[0] && st_reg.state[0] && !st_reg.sync2[0] &&
    (cfg_i.edge_sel[0] == GPBLK_EDGE_FALL || cfg_i.edge_sel[0] == GPBLK_EDGE_BOTH);
  endsequence

  a_sync_delay: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE16
    !cfg_i.in_dis[0] |-> ##3 (st_reg.state[0] == $past(pin_in_i[0], 3) || $past(cfg_i.in_dis[0])))
    else $error("pin state not three edges behind");

  a_edge_sets: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE11
    s_rise0 |=> st_reg.pend[0])
    else $error("rising edge missed");

  a_fall_sets: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE15
    s_fall0 |=> st_reg.pend[0])
    else $error("falling edge missed");

  a_set_wins: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE15
    (s_rise0 ##0 int_clr_i[0]) |=> st_reg.pend[0])
    else $error("clear beat a new edge");

  a_warm_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE16
    (!st_reg.fill3 && st_reg.pend == '0) |=> st_reg.pend == '0)
    else $error("edge taken before sync filled");

  a_in_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE10
    cfg_i.in_dis[0] |=> !st_reg.state[0])
    else $error("disabled input seen as high");

  a_no_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE15
    (!st_reg.pend[0] && cfg_i.edge_sel[0] == GPBLK_EDGE_NONE) |=> !st_reg.pend[0])
    else $error("pending without enable");

  a_clear_one: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE15
    (st_reg.pend[1] && int_clr_i[1] &&
     (cfg_i.edge_sel[1] == GPBLK_EDGE_NONE || st_reg.state[1] == st_reg.sync2[1])) |=> !st_reg.pend[1])
    else $error("pending not cleared");

  a_irq_merge: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE12
    irq_o == |int_pend_o)
    else $error("irq not or of pending");

  a_out_dis: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE4
    (cfg_i.out_dis[0] && !st_next.frozen) |=> !pad_o.out_en[0])
    else $error("driver on while disabled");

  a_hold_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE14
    (st_reg.frozen && !cfg_wr_i) |=> $stable(pad_o))
    else $error("held pad changed");

  a_freeze_on: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE5
    (hold_i && sleep_i) |=> $stable(pad_o))
    else $error("pad moved entering hold");

  a_frozen_src: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE5
    $rose(st_reg.frozen) |-> $past(hold_i) && $past(sleep_i))
    else $error("freeze without hold in sleep");

  a_in_en: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE4
    !st_next.frozen |=> pad_o.in_en == ~$past(cfg_i.in_dis))
    else $error("input enable not from config");

  a_mux_data: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE9
    (!cfg_i.periph_sel[0] && !st_next.frozen) |=> pad_o.out_val[0] == $past(cfg_i.data_out[0]))
    else $error("data register not on pin");

  a_periph_src: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE9
    (cfg_i.periph_sel[0] && !st_next.frozen) |=> pad_o.out_val[0] == $past(periph_out_i[0]))
    else $error("peripheral value not on pin");

  a_reset_drv: assert property (@(posedge clk_i) // RULE8
    !rst_b_i |-> pad_o.out_en == '0)
    else $error("driver on during reset");

  a_reset_off: assert property (@(posedge clk_i) // RULE8
    $rose(rst_b_i) |-> pad_o.out_en == '0)
    else $error("driver on after reset");

endmodule : gpblk_port

/* verilog/gpblk_pkg.sv */
package gpblk_pkg;
  // drive modes, three bits per pin
  localparam logic [2:0] GPBLK_DM_OFF    = 3'h0;
  localparam logic [2:0] GPBLK_DM_INONLY = 3'h1;
  localparam logic [2:0] GPBLK_DM_RES_PU = 3'h2;
  localparam logic [2:0] GPBLK_DM_RES_PD = 3'h3;
  localparam logic [2:0] GPBLK_DM_OD_LO  = 3'h4;
  localparam logic [2:0] GPBLK_DM_OD_HI  = 3'h5;
  localparam logic [2:0] GPBLK_DM_STRONG = 3'h6;
  localparam logic [2:0] GPBLK_DM_WEAK   = 3'h7;
  // interrupt edge select
  localparam logic [1:0] GPBLK_EDGE_NONE = 2'h0;
  localparam logic [1:0] GPBLK_EDGE_RISE = 2'h1;
  localparam logic [1:0] GPBLK_EDGE_FALL = 2'h2;
  localparam logic [1:0] GPBLK_EDGE_BOTH = 2'h3;
  localparam int GPBLK_PORT_W   = 8;
  localparam int GPBLK_MAX_PINS = 50;

  // per-port configuration from software
  typedef struct packed {
    logic [GPBLK_PORT_W-1:0][2:0] drive_mode;
    logic [GPBLK_PORT_W-1:0]      lvttl_sel;
    logic [GPBLK_PORT_W-1:0]      in_dis;
    logic [GPBLK_PORT_W-1:0]      out_dis;
    logic [GPBLK_PORT_W-1:0]      slew_slow;
    logic [GPBLK_PORT_W-1:0]      periph_sel;
    logic [GPBLK_PORT_W-1:0]      data_out;
    logic [GPBLK_PORT_W-1:0][1:0] edge_sel;
  } gpblk_cfg_t;

  // pad controls toward the analog cells
  typedef struct packed {
    logic [GPBLK_PORT_W-1:0][2:0] drive_mode;
    logic [GPBLK_PORT_W-1:0]      out_val;
    logic [GPBLK_PORT_W-1:0]      out_en;
    logic [GPBLK_PORT_W-1:0]      lvttl_sel;
    logic [GPBLK_PORT_W-1:0]      in_en;
    logic [GPBLK_PORT_W-1:0]      slew_slow;
  } gpblk_pad_t;
endpackage : gpblk_pkg

/* testbench/gpblk_pin_model.sv */
`timescale 1ns/10ps
// board side of one port: a driven pad wins, otherwise the outside level
module gpblk_pin_model
  import gpblk_pkg::*;
(
  input  wire gpblk_pad_t       pad_i,
  input  wire logic [7:0]       ext_i,
  output logic [7:0]            pin_o
);
  // trace delay keeps pin changes clear of the sampling edge
  assign #2 pin_o = (pad_i.out_en & pad_i.out_val) | (~pad_i.out_en & ext_i);
endmodule : gpblk_pin_model

/* testbench/gpblk_port_tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module gpblk_port_tb;
  import gpblk_pkg::*;
  logic       clk_i, rst_b_i, cfg_wr_i, hold_i, sleep_i, irq_o;
  gpblk_cfg_t cfg_i;
  gpblk_pad_t pad_o, saved;
  logic [7:0] periph_out_i, periph_oe_i, int_clr_i, pin_in_i, ext;
  logic [7:0] pin_state_o, periph_in_o, int_pend_o;
  logic [7:0] s1, s2, st, pd, ev;  // reference model state
  int         fill;                // edges since reset, gates edge events
  logic [95:0] rnd;
  int         errors, n_checks;
  gpblk_port DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg_i), .cfg_wr_i(cfg_wr_i),
    .hold_i(hold_i), .sleep_i(sleep_i), .periph_out_i(periph_out_i),
    .periph_oe_i(periph_oe_i), .int_clr_i(int_clr_i), .pin_in_i(pin_in_i), .pad_o(pad_o),
    .pin_state_o(pin_state_o), .periph_in_o(periph_in_o), .int_pend_o(int_pend_o),
    .irq_o(irq_o));
  gpblk_pin_model PINS (.pad_i(pad_o), .ext_i(ext), .pin_o(pin_in_i));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // reference model, one step per clock; set beats clear
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {s1, s2, st, pd} = '0;
      fill = 0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        ev[i] = ~cfg_i.in_dis[i] & (cfg_i.edge_sel[i][0] & s2[i] & ~st[i]
                | cfg_i.edge_sel[i][1] & ~s2[i] & st[i]);
      end
      if (fill < 3) ev = 8'h00;  // no edges until the sync chain holds the pin
      pd = (pd & ~int_clr_i) | ev;
      st = s2 & ~cfg_i.in_dis;
      s2 = s1;
      s1 = pin_in_i;
      fill++;
    end
  end
  task automatic cyc(input int n);
    repeat (n) begin
      @(negedge clk_i);
      `CHK(pin_state_o, st)
      `CHK(periph_in_o, st)
      `CHK(int_pend_o, pd)
      `CHK(irq_o, |pd)
      ext = 8'($urandom);
      int_clr_i = 8'($urandom & $urandom);
    end
  endtask : cyc
  task automatic chk_pad();
    logic en;
    for (int i = 0; i < 8; i++) begin
      en = cfg_i.drive_mode[i] != GPBLK_DM_OFF && cfg_i.drive_mode[i] != GPBLK_DM_INONLY;
      en = en && !cfg_i.out_dis[i] && (!cfg_i.periph_sel[i] || periph_oe_i[i]);
      `CHK(pad_o.out_en[i], en)
      `CHK(pad_o.drive_mode[i], cfg_i.drive_mode[i])
      `CHK(pad_o.out_val[i], cfg_i.periph_sel[i] ? periph_out_i[i] : cfg_i.data_out[i])
    end
    `CHK(pad_o.lvttl_sel, cfg_i.lvttl_sel)
    `CHK(pad_o.in_en, ~cfg_i.in_dis)
    `CHK(pad_o.out_en & cfg_i.out_dis, 8'h00)
    `CHK(pad_o.slew_slow, cfg_i.slew_slow)
  endtask : chk_pad
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h945a));
    {rst_b_i, cfg_wr_i, hold_i, sleep_i} = '0;
    {periph_out_i, periph_oe_i, int_clr_i, ext} = '0;
    cfg_i = '0;
    repeat (5) @(negedge clk_i);
    `CHK(pad_o, gpblk_pad_t'('0))
    rst_b_i = 1'b1;
    // random configurations; port halves take turns at input disable, and pin 0
    // walks rising, falling and both edges while it listens to the outside level
    for (int k = 0; k < 6; k++) begin
      rnd = {$urandom, $urandom, $urandom};
      cfg_i = gpblk_cfg_t'(rnd[79:0]);
      cfg_i.in_dis = k[0] ? 8'hf0 : 8'h0f;
      cfg_i.out_dis[0] = k[0];
      cfg_i.edge_sel[0] = k[0] ? 2'(k / 2 + 1) : GPBLK_EDGE_NONE;
      for (int i = 0; i < 8; i++) cfg_i.drive_mode[i] = 3'($urandom);
      {periph_out_i, periph_oe_i} = 16'($urandom);
      cyc(40);
      chk_pad();
    end
    // deep sleep with hold: pads ignore new settings until a fresh write
    hold_i = 1'b1;
    sleep_i = 1'b1;
    repeat (2) @(negedge clk_i);
    saved = pad_o;
    cfg_i.data_out = ~cfg_i.data_out;
    cfg_i.slew_slow = ~cfg_i.slew_slow;
    repeat (3) @(negedge clk_i);
    `CHK(pad_o, saved)
    {hold_i, sleep_i, cfg_wr_i} = 3'h1;
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
    @(negedge clk_i);
    chk_pad();
    // reset out of held sleep leaves pads undriven
    {hold_i, sleep_i} = 2'h3;
    repeat (2) @(negedge clk_i);
    {rst_b_i, hold_i, sleep_i} = '0;
    @(negedge clk_i);
    `CHK(pad_o, gpblk_pad_t'('0))
    rst_b_i = 1'b1;
    cyc(20);
    chk_pad();
    stop_test();
  end
endmodule : gpblk_port_tb
